// >>> hw/supply_status_pkg.sv
/*
  Shared constants for the supply status bank: command codes, status bit
  positions, page codes, forced power-good codes and the readback period.
  Assumes a 250 MHz core clock.
*/
package supply_status_pkg;

  // Widths and channel count.
  localparam int MAX_CHANNELS = 16;
  localparam int CMD_W        = 8;
  localparam int DATA_W       = 16;
  localparam int BYTE_W       = 8;

  // Read command codes.
  localparam logic [7:0] CMD_SUMMARY_WORD  = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS   = 8'h7A;
  localparam logic [7:0] CMD_TEMP_STATUS   = 8'h7D;
  localparam logic [7:0] CMD_COMM_STATUS   = 8'h7E;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_MEASURED_VOUT = 8'h8B;

  // Page selecting the global view.
  localparam logic [7:0] PAGE_GLOBAL = 8'hFF;

  // Summary word bit positions.
  localparam int SW_VOUT_BIT   = 15;
  localparam int SW_VENDOR_BIT = 12;
  localparam int SW_PGLOST_BIT = 11;
  localparam int SW_MARGIN_BIT = 8;
  localparam int SW_OFF_BIT    = 6;
  localparam int SW_OV_BIT     = 5;
  localparam int SW_TEMP_BIT   = 2;
  localparam int SW_COMM_BIT   = 1;

  // Output-voltage status byte bit positions.
  localparam int VS_OVF_BIT = 7;
  localparam int VS_OVW_BIT = 6;
  localparam int VS_UVW_BIT = 5;
  localparam int VS_UVF_BIT = 4;
  localparam int VS_TON_BIT = 2;

  // Index of each flag in the five-bit latched output-voltage set.
  localparam int VF_OVF = 4;
  localparam int VF_OVW = 3;
  localparam int VF_UVW = 2;
  localparam int VF_UVF = 1;
  localparam int VF_TON = 0;
  localparam int VF_W   = 5;

  // Temperature and communication byte bit positions.
  localparam int TS_OTF_BIT  = 7;
  localparam int TS_OTW_BIT  = 6;
  localparam int CS_CMD_BIT  = 7;
  localparam int CS_DATA_BIT = 6;
  localparam int CS_FULL_BIT = 0;

  // Vendor byte bit positions, channel pages.
  localparam int VC_OFF_BIT    = 7;
  localparam int VC_MARGIN_BIT = 3;
  localparam int VC_PGLOST_BIT = 2;

  // Bits of the global vendor byte that pass through; bits 2 to 0 always read zero.
  localparam logic [7:0] GLOBAL_VENDOR_MASK = 8'hF8;

  // Forced power-good codes of the on threshold.
  localparam logic [15:0] PG_FORCE_BAD  = 16'h7FFF;
  localparam logic [15:0] PG_FORCE_GOOD = 16'h0000;

  // Readback refresh period.
  localparam int VOUT_REFRESH_MS  = 5;
  localparam int CORE_CLK_KHZ     = 250_000;
  localparam int VOUT_REFRESH_CYC = VOUT_REFRESH_MS * CORE_CLK_KHZ;

endpackage

// >>> hw/chan_flag_if.sv
/*
  Per-channel sequencer flags passed from the channel tracker to the bank.
  Assumes one clock domain shared by both modules.
*/
interface chan_flag_if #(
  parameter int N = 16
);
  logic         clear;
  logic [N-1:0] off;
  logic [N-1:0] pg_lost;
  logic [N-1:0] margin;

  modport owner (input clear, output off, output pg_lost, output margin);
  modport user  (output clear, input off, input pg_lost, input margin);
endinterface

// >>> hw/chan_flag_track.sv
/*
  Tracks the sequenced-off, power-good-lost and margin fault flags of each
  channel. Assumes threshold comparisons and sequencer state arrive as
  synchronous levels and that margin failures arrive as one-cycle pulses.
*/
module chan_flag_track
  import supply_status_pkg::*;
#(
  parameter int N = 16
) (
  // Clock, reset and enable.
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            ce_i,
  // Sequencer and comparator state.
  input  wire logic [N-1:0]    ch_enabled_i,
  input  wire logic [N-1:0]    supply_enable_out_i,
  input  wire logic [N-1:0]    above_on_i,
  input  wire logic [N-1:0]    below_off_i,
  input  wire logic [N*16-1:0] pg_on_thr_i,
  input  wire logic [N-1:0]    margin_fail_i,
  // Flags towards the bank.
  chan_flag_if.owner           flags
);

  typedef struct packed {
    logic [N-1:0] good;
    logic [N-1:0] margin;
  } track_s;

  track_s       s_r;
  track_s       s_nxt;
  logic [N-1:0] good_nxt;

  for (genvar ch = 0; ch < N; ch++) begin : g_ch
    logic [15:0] thr;
    assign thr = pg_on_thr_i[ch*16 +: 16];
    // Forced codes override the measured state.
    always_comb begin
      if (thr == PG_FORCE_GOOD) begin
        good_nxt[ch] = 1'b1;
      end else if (thr == PG_FORCE_BAD) begin
        good_nxt[ch] = 1'b0;
      end else if (above_on_i[ch]) begin
        good_nxt[ch] = 1'b1;
      end else if (below_off_i[ch]) begin
        good_nxt[ch] = 1'b0;
      end else begin
        good_nxt[ch] = s_r.good[ch];
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    if (ce_i) begin
      s_nxt.good   = good_nxt;
      s_nxt.margin = (s_r.margin & ~{N{flags.clear}}) | margin_fail_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flags.off     = ch_enabled_i & ~supply_enable_out_i;
  assign flags.pg_lost = ~s_r.good;
  assign flags.margin  = s_r.margin;

endmodule // chan_flag_track

// >>> hw/supply_status_bank.sv
/*
  Status reporting bank of a multi-channel supply monitor: summary word,
  latched output-voltage, temperature and communication status, per-page
  vendor status and a periodically refreshed voltage readback.
  Assumes a command decoder delivers read, page and clear requests as
  one-cycle synchronous pulses, and that fault conditions arrive as levels.
*/
module supply_status_bank
  import supply_status_pkg::*;
#(
  parameter int N              = MAX_CHANNELS,
  parameter int REFRESH_CYCLES = VOUT_REFRESH_CYC
) (
  // Clock, reset and enable.
  input  wire logic                                CORE_CLK_I,
  input  wire logic                                RST_B_I,
  input  wire logic                                CE_I,
  // Host command port.
  input  wire logic                                CMD_RD_I,
  input  wire logic [supply_status_pkg::CMD_W-1:0] CMD_CODE_I,
  input  wire logic                                PAGE_WR_I,
  input  wire logic [supply_status_pkg::CMD_W-1:0] PAGE_I,
  input  wire logic                                CLEAR_FAULTS_I,
  input  wire logic                                COMM_ERR_I,
  input  wire logic                                DATA_ERR_I,
  output logic      [supply_status_pkg::DATA_W-1:0] RD_DATA_O,
  output logic                                     RD_VALID_O,
  // Output-voltage conditions per channel.
  input  wire logic [N-1:0]                        OV_FAULT_I,
  input  wire logic [N-1:0]                        OV_WARN_I,
  input  wire logic [N-1:0]                        UV_WARN_I,
  input  wire logic [N-1:0]                        UV_FAULT_I,
  input  wire logic [N-1:0]                        TON_MAX_I,
  // Temperature conditions.
  input  wire logic                                OT_FAULT_I,
  input  wire logic                                OT_WARN_I,
  // Event record state.
  input  wire logic                                RECORD_FULL_I,
  input  wire logic                                RECORD_WRAP_EN_I,
  input  wire logic                                RECORD_OVERWRITING_I,
  // Sequencer and comparator state.
  input  wire logic [N-1:0]                        CH_ENABLED_I,
  input  wire logic [N-1:0]                        SUPPLY_ENABLE_OUT_I,
  input  wire logic [N-1:0]                        ABOVE_ON_I,
  input  wire logic [N-1:0]                        BELOW_OFF_I,
  input  wire logic [N*16-1:0]                     PG_ON_THR_I,
  input  wire logic [N-1:0]                        MARGIN_FAIL_I,
  input  wire logic [supply_status_pkg::BYTE_W-1:0] GLOBAL_VENDOR_I,
  // Measured voltages.
  input  wire logic [N*16-1:0]                     MEAS_VOUT_I,
  // Status outputs.
  output logic      [supply_status_pkg::DATA_W-1:0] STATUS_WORD_O,
  output logic                                     ALERT_REQ_O
);

  import supply_status_pkg::*;

  localparam int CW  = $clog2(REFRESH_CYCLES + 1);
  localparam int CHW = $clog2(MAX_CHANNELS);

  if (N < 1 || N > MAX_CHANNELS) begin : g_bad_n
    $error("Channel count must lie between 1 and 16.");
  end
  if (REFRESH_CYCLES < 1) begin : g_bad_refresh
    $error("Refresh period must be at least one cycle.");
  end

  typedef struct packed {
    logic [N-1:0][VF_W-1:0] vout;
    logic [1:0]             temp;
    logic [1:0]             comm;
    logic [7:0]             page;
    logic [15:0]            word;
    logic [15:0]            rd_data;
    logic                   rd_valid;
    logic                   alert;
    logic [CW-1:0]          tick_cnt;
    logic [N-1:0][15:0]     meas;
  } bank_s;

  bank_s            s_r;
  bank_s            s_nxt;
  logic [N-1:0]     any_vout;
  logic [N-1:0]     any_ov;
  logic             log_full;
  logic             page_ok;
  logic             chan_sel;
  logic [CHW-1:0]   idx;
  logic [15:0]      rd_mux;
  logic [15:0]      word_nxt;

  chan_flag_if #(.N(N)) chf ();

  chan_flag_track #(.N(N)) u_track (
    .clk_i               (CORE_CLK_I),
    .rst_b_i             (RST_B_I),
    .ce_i                (CE_I),
    .ch_enabled_i        (CH_ENABLED_I),
    .supply_enable_out_i (SUPPLY_ENABLE_OUT_I),
    .above_on_i          (ABOVE_ON_I),
    .below_off_i         (BELOW_OFF_I),
    .pg_on_thr_i         (PG_ON_THR_I),
    .margin_fail_i       (MARGIN_FAIL_I),
    .flags               (chf.owner)
  );

  assign chf.clear = CLEAR_FAULTS_I;

  // Known read commands of this bank.
  function automatic logic cmd_known(input logic [7:0] code);
    case (code)
      CMD_SUMMARY_WORD, CMD_VOUT_STATUS, CMD_TEMP_STATUS,
      CMD_COMM_STATUS, CMD_VENDOR_STATUS, CMD_MEASURED_VOUT: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction

  // Places the five latched flags at their byte positions.
  function automatic logic [7:0] vout_byte(input logic [VF_W-1:0] f);
    logic [7:0] b;
    b             = 8'h00;
    b[VS_OVF_BIT] = f[VF_OVF];
    b[VS_OVW_BIT] = f[VF_OVW];
    b[VS_UVW_BIT] = f[VF_UVW];
    b[VS_UVF_BIT] = f[VF_UVF];
    b[VS_TON_BIT] = f[VF_TON];
    return b;
  endfunction

  for (genvar ch = 0; ch < N; ch++) begin : g_any
    assign any_vout[ch] = |s_r.vout[ch];
    assign any_ov[ch]   = s_r.vout[ch][VF_OVF];
  end

  assign log_full = RECORD_FULL_I & ~(RECORD_WRAP_EN_I & RECORD_OVERWRITING_I);
  assign page_ok  = (PAGE_I < 8'(N)) || (PAGE_I == PAGE_GLOBAL);
  assign chan_sel = s_r.page < 8'(N);
  assign idx      = s_r.page[CHW-1:0];

  // Summary word, unused positions stay zero.
  always_comb begin
    word_nxt                = 16'h0000;
    word_nxt[SW_VOUT_BIT]   = |any_vout;
    word_nxt[SW_VENDOR_BIT] = |(GLOBAL_VENDOR_I & GLOBAL_VENDOR_MASK);
    word_nxt[SW_PGLOST_BIT] = |chf.pg_lost;
    word_nxt[SW_MARGIN_BIT] = |chf.margin;
    word_nxt[SW_OFF_BIT]    = |chf.off;
    word_nxt[SW_OV_BIT]     = |any_ov;
    word_nxt[SW_TEMP_BIT]   = |s_r.temp;
    word_nxt[SW_COMM_BIT]   = |s_r.comm | log_full;
  end

  // Read answer for the currently selected page.
  always_comb begin
    rd_mux = 16'h0000;
    case (CMD_CODE_I)
      CMD_SUMMARY_WORD: begin
        rd_mux = s_r.word;
      end
      CMD_VOUT_STATUS: begin
        if (chan_sel) begin
          rd_mux[7:0] = vout_byte(s_r.vout[idx]);
        end
      end
      CMD_TEMP_STATUS: begin
        rd_mux[TS_OTF_BIT] = s_r.temp[1];
        rd_mux[TS_OTW_BIT] = s_r.temp[0];
      end
      CMD_COMM_STATUS: begin
        rd_mux[CS_CMD_BIT]  = s_r.comm[1];
        rd_mux[CS_DATA_BIT] = s_r.comm[0];
        rd_mux[CS_FULL_BIT] = log_full;
      end
      CMD_VENDOR_STATUS: begin
        if (chan_sel) begin
          rd_mux[VC_OFF_BIT]    = chf.off[idx];
          rd_mux[VC_MARGIN_BIT] = chf.margin[idx];
          rd_mux[VC_PGLOST_BIT] = chf.pg_lost[idx];
        end else if (s_r.page == PAGE_GLOBAL) begin
          rd_mux[7:0] = GLOBAL_VENDOR_I & GLOBAL_VENDOR_MASK;
        end
      end
      CMD_MEASURED_VOUT: begin
        if (chan_sel) begin
          rd_mux = s_r.meas[idx];
        end
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_comb begin
    logic             clr;
    logic [VF_W-1:0]  cond;
    logic [1:0]       comm_evt;
    logic             fresh;
    clr      = CLEAR_FAULTS_I;
    cond     = '0;
    comm_evt = '0;
    fresh    = 1'b0;
    s_nxt    = s_r;
    if (CE_I) begin
      s_nxt.rd_valid = 1'b0;
      // Set wins over a clear in the same cycle.
      for (int ch = 0; ch < N; ch++) begin
        cond         = '0;
        cond[VF_OVF] = OV_FAULT_I[ch];
        cond[VF_OVW] = OV_WARN_I[ch];
        cond[VF_UVW] = UV_WARN_I[ch];
        cond[VF_UVF] = UV_FAULT_I[ch];
        cond[VF_TON] = TON_MAX_I[ch];
        s_nxt.vout[ch] = (s_r.vout[ch] & ~{VF_W{clr}}) | cond;
        fresh = fresh | (|(cond & ~s_r.vout[ch]));
      end
      s_nxt.temp = (s_r.temp & ~{2{clr}}) | {OT_FAULT_I, OT_WARN_I};
      comm_evt[1] = COMM_ERR_I | (CMD_RD_I & ~cmd_known(CMD_CODE_I));
      comm_evt[0] = DATA_ERR_I | (PAGE_WR_I & ~page_ok);
      s_nxt.comm  = (s_r.comm & ~{2{clr}}) | comm_evt;
      fresh = fresh | (|({OT_FAULT_I, OT_WARN_I} & ~s_r.temp));
      fresh = fresh | (|(comm_evt & ~s_r.comm));
      fresh = fresh | (|(MARGIN_FAIL_I & ~chf.margin));
      s_nxt.alert = fresh;
      if (PAGE_WR_I && page_ok) begin
        s_nxt.page = PAGE_I;
      end
      s_nxt.word = word_nxt;
      if (s_r.tick_cnt == CW'(REFRESH_CYCLES - 1)) begin
        s_nxt.tick_cnt = '0;
        s_nxt.meas     = MEAS_VOUT_I;
      end else begin
        s_nxt.tick_cnt = s_r.tick_cnt + CW'(1);
      end
      if (CMD_RD_I) begin
        s_nxt.rd_valid = 1'b1;
        s_nxt.rd_data  = rd_mux;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RD_DATA_O     = s_r.rd_data;
  assign RD_VALID_O    = s_r.rd_valid;
  assign STATUS_WORD_O = s_r.word;
  assign ALERT_REQ_O   = s_r.alert;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  read_answer_a: assert property (
    CE_I && CMD_RD_I |=> RD_VALID_O
  ) else $error("Read not answered in one cycle.");

  word_zeros_a: assert property (
    (STATUS_WORD_O & 16'h6699) == 16'h0000
  ) else $error("Unused summary bit set.");

  timeout_latch_a: assert property (
    CE_I && TON_MAX_I[0] ##1 CE_I && !CLEAR_FAULTS_I |=> s_r.vout[0][VF_TON]
  ) else $error("Timeout flag lost before clear.");

  temp_reset_a: assert property (
    CE_I && CLEAR_FAULTS_I && OT_FAULT_I |=> s_r.temp[1]
  ) else $error("Persisting overtemperature cleared.");

  comm_latch_a: assert property (
    CE_I && COMM_ERR_I |=> s_r.comm[1] ##1 (s_r.comm[1] || $past(CLEAR_FAULTS_I))
  ) else $error("Command error not latched.");

  log_full_a: assert property (
    CE_I && CMD_RD_I && CMD_CODE_I == CMD_COMM_STATUS && RECORD_WRAP_EN_I
      && RECORD_OVERWRITING_I |=> !RD_DATA_O[CS_FULL_BIT]
  ) else $error("Full flag shown while overwriting.");

  vout_word_a: assert property (
    CE_I && OV_WARN_I[0] ##1 CE_I |=> STATUS_WORD_O[SW_VOUT_BIT]
  ) else $error("Voltage summary bit missing.");

  pglost_word_a: assert property (
    CE_I && (|chf.pg_lost) |=> STATUS_WORD_O[SW_PGLOST_BIT]
  ) else $error("Power-good-lost summary missing.");

  off_word_a: assert property (
    CE_I && (|chf.off) |=> STATUS_WORD_O[SW_OFF_BIT]
  ) else $error("Sequenced-off summary missing.");

  off_alert_a: assert property (
    CE_I && $rose(|chf.off) && !(|OV_FAULT_I) && !(|OV_WARN_I) && !(|UV_WARN_I)
      && !(|UV_FAULT_I) && !(|TON_MAX_I) && !OT_FAULT_I && !OT_WARN_I
      && !COMM_ERR_I && !DATA_ERR_I && !CMD_RD_I && !PAGE_WR_I
      && !(|MARGIN_FAIL_I) |=> !ALERT_REQ_O
  ) else $error("Off flag raised an alert.");

endmodule // supply_status_bank

// >>> tb/host_model.sv
/*
  Host controller model for the status bank: page select, clear and read.
  Assumes the bank takes each request at a rising edge and strobes its answer.
*/
module host_model (
  // Clock and answer.
  input  wire logic        clk_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  // Requests.
  output logic             rd_o,
  output logic [7:0]       code_o,
  output logic             page_wr_o,
  output logic [7:0]       page_o,
  output logic             clear_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_o      = 1'b0;
    code_o    = 8'h00;
    page_wr_o = 1'b0;
    page_o    = 8'h00;
    clear_o   = 1'b0;
  end

  // Selects the page before any page-dependent read.
  task automatic sel(input logic [7:0] p);
    @(negedge clk_i);
    page_o    = p;
    page_wr_o = 1'b1;
    @(negedge clk_i);
    page_wr_o = 1'b0;
    page_o    = ~p;
  endtask

  task automatic clr();
    @(negedge clk_i);
    clear_o = 1'b1;
    @(negedge clk_i);
    clear_o = 1'b0;
  endtask

  // Issues one read and waits a bounded time for the answer strobe.
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge clk_i);
    code_o = c;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    code_o = ~c;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        d  = rd_data_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask
endmodule // host_model

// >>> tb/tb_supply_status_bank.sv
/*
  Self-checking bench for the supply status bank: reads every status command
  through the host model. Assumes a short readback period of 8 cycles.
*/
module tb_supply_status_bank
  import supply_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NC = 16;
  localparam logic [7:0] T_CMD [9] = '{CMD_VOUT_STATUS, CMD_VOUT_STATUS, CMD_VOUT_STATUS,
    CMD_VOUT_STATUS, CMD_VOUT_STATUS, CMD_TEMP_STATUS, CMD_TEMP_STATUS, CMD_COMM_STATUS,
    CMD_COMM_STATUS};
  localparam logic [7:0] T_BYTE [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h80, 8'h40,
    8'h80, 8'h40};
  localparam logic [15:0] T_SUM [9] = '{16'h8020, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
    16'h0004, 16'h0004, 16'h0002, 16'h0002};

  logic             clk, rst_b, rd, pg_wr, clr, rd_v, alert, full, wrap, ovw, lvl, ce;
  logic [7:0]       code, page, gvend;
  logic [15:0]      rdat, sword, eb;
  logic [NC-1:0]    en, seq_en, above, below, mfail;
  logic [NC-1:0]    ch_sel, ov_flt, ov_wrn, uv_wrn, uv_flt, ton_evt;
  logic [NC*16-1:0] thr, meas;
  logic [8:0]       cond;
  int               n_fail, n_checks, n_alert, cyc;

  // Output-voltage conditions reach every channel selected in ch_sel.
  assign ov_flt  = ch_sel & {NC{cond[0]}};
  assign ov_wrn  = ch_sel & {NC{cond[1]}};
  assign uv_wrn  = ch_sel & {NC{cond[2]}};
  assign uv_flt  = ch_sel & {NC{cond[3]}};
  assign ton_evt = ch_sel & {NC{cond[4]}};

  supply_status_bank #(.N(NC), .REFRESH_CYCLES(8)) i_dut (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .CMD_RD_I(rd), .CMD_CODE_I(code),
    .PAGE_WR_I(pg_wr), .PAGE_I(page), .CLEAR_FAULTS_I(clr), .COMM_ERR_I(cond[7]),
    .DATA_ERR_I(cond[8]), .RD_DATA_O(rdat), .RD_VALID_O(rd_v),
    .OV_FAULT_I(ov_flt), .OV_WARN_I(ov_wrn), .UV_WARN_I(uv_wrn), .UV_FAULT_I(uv_flt),
    .TON_MAX_I(ton_evt), .OT_FAULT_I(cond[5]), .OT_WARN_I(cond[6]),
    .RECORD_FULL_I(full), .RECORD_WRAP_EN_I(wrap), .RECORD_OVERWRITING_I(ovw),
    .CH_ENABLED_I(en), .SUPPLY_ENABLE_OUT_I(seq_en), .ABOVE_ON_I(above),
    .BELOW_OFF_I(below), .PG_ON_THR_I(thr), .MARGIN_FAIL_I(mfail),
    .GLOBAL_VENDOR_I(gvend), .MEAS_VOUT_I(meas), .STATUS_WORD_O(sword),
    .ALERT_REQ_O(alert));

  host_model i_host (.clk_i(clk), .rd_valid_i(rd_v), .rd_data_i(rdat), .rd_o(rd),
    .code_o(code), .page_wr_o(pg_wr), .page_o(page), .clear_o(clr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Counts alert pulses and cuts a hang short.
  always @(negedge clk) begin
    cyc++;
    if (alert === 1'b1) n_alert++;
    if (cyc == 20000) begin
      n_fail++;
      $display("unexpected %0t timeout", $time);
      close_out();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    i_host.rd(c, d, ok);
    cmp({15'h0000, ok}, 16'h0001);
    cmp(d, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    ch_sel = 16'h0003;
    {full, wrap, ovw, gvend, cond, mfail, meas} = '0;
    {seq_en, above, below} = '0;
    en = '1;
    thr = {NC{16'h1234}};
    wt(16);
    rst_b = 1'b1;
    wt(3);
    i_host.sel(8'h00);
    chk(CMD_VENDOR_STATUS, 16'h0084);
    chk(CMD_SUMMARY_WORD, 16'h0840);
    seq_en = '1;
    above = '1;
    wt(3);
    chk(CMD_SUMMARY_WORD, 16'h0000);
    above[3] = 1'b0;
    below[3] = 1'b1;
    wt(3);
    i_host.sel(8'h03);
    chk(CMD_VENDOR_STATUS, 16'h0004);
    chk(CMD_SUMMARY_WORD, 16'h0800);
    i_host.sel(8'h00);
    chk(CMD_VENDOR_STATUS, 16'h0000);
    above[3] = 1'b1;
    below[3] = 1'b0;
    wt(3);
    i_host.sel(8'h03);
    chk(CMD_VENDOR_STATUS, 16'h0000);
    thr[5*16+:16] = PG_FORCE_BAD;
    wt(3);
    i_host.sel(8'h05);
    chk(CMD_VENDOR_STATUS, 16'h0004);
    thr[5*16+:16] = PG_FORCE_GOOD;
    above[5] = 1'b0;
    below[5] = 1'b1;
    wt(3);
    chk(CMD_VENDOR_STATUS, 16'h0000);
    above[5] = 1'b1;
    below[5] = 1'b0;
    seq_en[2] = 1'b0;
    wt(3);
    i_host.sel(8'h02);
    chk(CMD_VENDOR_STATUS, 16'h0080);
    chk(CMD_SUMMARY_WORD, 16'h0040);
    en[2] = 1'b0;
    wt(3);
    chk(CMD_VENDOR_STATUS, 16'h0000);
    en[2] = 1'b1;
    seq_en[2] = 1'b1;
    cmp(16'(n_alert == 0), 16'h0001);
    @(negedge clk);
    mfail[6] = 1'b1;
    @(negedge clk);
    mfail[6] = 1'b0;
    wt(3);
    i_host.sel(8'h06);
    chk(CMD_VENDOR_STATUS, 16'h0008);
    chk(CMD_SUMMARY_WORD, 16'h0100);
    i_host.clr();
    chk(CMD_VENDOR_STATUS, 16'h0000);
    i_host.sel(8'h01);
    for (int k = 0; k < 9; k++) begin
      lvl = !(k == 4 || k >= 7);
      eb = {8'h00, T_BYTE[k]};
      @(negedge clk);
      cond[k] = 1'b1;
      if (!lvl) begin
        @(negedge clk);
        cond[k] = 1'b0;
      end
      wt(3);
      chk(T_CMD[k], eb);
      chk(CMD_SUMMARY_WORD, T_SUM[k]);
      cmp(sword, T_SUM[k]);
      i_host.clr();
      wt(3);
      chk(T_CMD[k], lvl ? eb : 16'h0000);
      @(negedge clk);
      cond[k] = 1'b0;
      wt(3);
      chk(T_CMD[k], lvl ? eb : 16'h0000);
      i_host.clr();
      wt(3);
      chk(T_CMD[k], 16'h0000);
    end
    cmp(16'(n_alert > 0), 16'h0001);
    chk(8'h55, 16'h0000);
    chk(CMD_COMM_STATUS, 16'h0080);
    i_host.clr();
    i_host.sel(8'h20);
    chk(CMD_COMM_STATUS, 16'h0040);
    i_host.clr();
    full = 1'b1;
    wt(3);
    chk(CMD_COMM_STATUS, 16'h0001);
    chk(CMD_SUMMARY_WORD, 16'h0002);
    wrap = 1'b1;
    ovw = 1'b1;
    wt(3);
    chk(CMD_COMM_STATUS, 16'h0000);
    {full, wrap, ovw} = '0;
    gvend = 8'h0F;
    wt(3);
    i_host.sel(PAGE_GLOBAL);
    chk(CMD_VENDOR_STATUS, 16'h0008);
    chk(CMD_SUMMARY_WORD, 16'h1000);
    chk(CMD_MEASURED_VOUT, 16'h0000);
    gvend = 8'h07;
    wt(3);
    chk(CMD_SUMMARY_WORD, 16'h0000);
    meas[4*16+:16] = 16'hABCD;
    i_host.sel(8'h04);
    wt(12);
    chk(CMD_MEASURED_VOUT, 16'hABCD);
    meas[4*16+:16] = 16'h1357;
    wt(12);
    chk(CMD_MEASURED_VOUT, 16'h1357);
    ce = 1'b0;
    above[7] = 1'b0;
    below[7] = 1'b1;
    wt(3);
    cmp(sword, 16'h0000);
    ce = 1'b1;
    wt(3);
    cmp(sword, 16'h0800);
    close_out();
  end
endmodule // tb_supply_status_bank
